// [mq_flag_pkg.sv]
// shared constants and types for the multi-queue flag bus logic
package mq_flag_pkg;

  localparam int QUEUES    = 32;
  localparam int QUAD_BITS = 8;
  localparam int QUADS     = 4;
  localparam int ADDR_W    = 8;
  localparam int ID_W      = 3;
  localparam int QSEL_W    = 5;
  localparam int QUAD_W    = 2;
  // address fields: device id on top, quadrant inside the queue field
  localparam int ID_LSB    = 5;
  localparam int QUAD_LSB  = 3;
  localparam int QUEUE_LSB = 0;

  localparam logic [QUAD_W-1:0]    QUAD_FIRST = 2'h0;
  localparam logic [QUAD_W-1:0]    QUAD_LAST  = 2'h3;
  localparam logic [QUAD_BITS-1:0] BUS_IDLE_N = 8'hFF;

  typedef enum logic {
    MODE_DIRECT = 1'b0,
    MODE_POLLED = 1'b1
  } bus_mode_t;

  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_SHOW = 1'b1
  } chan_state_t;

  typedef struct packed {
    chan_state_t            state;
    logic [QUAD_W-1:0]      quad;
    logic                   sync;
    logic                   tokenOut;
    logic [QUAD_BITS-1:0]   busN;
  } chan_t;

  // controller registers on APB, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WSEL   = 8'h04;
  localparam logic [7:0] REG_FSEL   = 8'h08;
  localparam logic [7:0] REG_ESEL   = 8'h0C;
  localparam logic [7:0] REG_WRITE  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // status word fields
  localparam int ST_FULL_N  = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_AFSYNC  = 2;
  localparam int ST_AESYNC  = 3;
  localparam int ST_AFBUS   = 8;
  localparam int ST_AEBUS   = 16;
  localparam int ST_WCOUNT  = 24;
  localparam int WCOUNT_W   = 8;

endpackage

// [mq_flag_if.sv]
// link between the flag logic of one device and the user logic beside it
`timescale 1ns/1ps
`default_nettype none
interface mq_flag_if;
  import mq_flag_pkg::*;

  logic                   flagBusModeSelect;
  logic [ADDR_W-1:0]      writeQueueAddress;
  logic                   writeAddressStrobe;
  logic                   almostFullBusStrobe;
  logic [ADDR_W-1:0]      readQueueAddress;
  logic                   almostEmptyBusStrobe;
  logic                   fullTokenIn;
  logic                   emptyTokenIn;
  logic                   fullTokenOut;
  logic                   emptyTokenOut;
  logic                   writeQueueFullFlagOut;
  logic                   writeQueueFullFlagEnN;
  logic [QUAD_BITS-1:0]   almostFullStatusBusN;
  logic [QUAD_BITS-1:0]   almostEmptyStatusBusN;
  logic                   almostFullBusSync;
  logic                   almostEmptyBusSync;
  logic                   writeQueueFullFlagN;

  // shared line is pulled up when no device drives it
  assign writeQueueFullFlagN = writeQueueFullFlagEnN ? 1'b1 : writeQueueFullFlagOut;

  modport device (
    input  flagBusModeSelect, writeQueueAddress, writeAddressStrobe, almostFullBusStrobe,
           readQueueAddress, almostEmptyBusStrobe, fullTokenIn, emptyTokenIn,
    output fullTokenOut, emptyTokenOut, writeQueueFullFlagOut, writeQueueFullFlagEnN,
           almostFullStatusBusN, almostEmptyStatusBusN, almostFullBusSync, almostEmptyBusSync
  );

  modport user (
    output flagBusModeSelect, writeQueueAddress, writeAddressStrobe, almostFullBusStrobe,
           readQueueAddress, almostEmptyBusStrobe, fullTokenIn, emptyTokenIn,
    input  fullTokenOut, emptyTokenOut, writeQueueFullFlagN,
           almostFullStatusBusN, almostEmptyStatusBusN, almostFullBusSync, almostEmptyBusSync
  );
endinterface // mq_flag_if
`default_nettype wire

// [mq_flag_device.sv]
// flag logic of one multi-queue device: full flag line and two status buses
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - polled chain: accept empty token from predecessor
// - single polled device loops empty token back
// - direct mode: empty token input held low
// - pulse empty token after fourth quadrant shown
// - token received: first quadrant on next edge
// - chain outputs feed next inputs, last to first
// - full flag tracks selected queue, one cycle later
// - writer writes only while full flag high
// - only owning device drives shared full line
// - newly owning device drives full on next cycle
// - mode pin latched at reset: high polled
// - direct: strobe captures almost-full quadrant address
// - polled: almost-full strobe held low
// - polled: almost-full quadrants rotate, fifth wraps
// - almost-full sync high with quadrant one
// - polled chain: accept full token from predecessor
// - single polled device loops full token back
// - direct mode: full token input held low
// - pulse full token after fourth quadrant shown
// - polled almost-empty rotation with its sync
// - direct: strobe captures almost-empty quadrant address
module mq_flag_device
  import mq_flag_pkg::*;
#(
  parameter int QUEUE_COUNT = QUEUES
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  mq_flag_if.device                   link,
  input  wire logic [ID_W-1:0]        deviceId,
  input  wire logic                   ringLeader,
  input  wire logic [QUEUE_COUNT-1:0] queueFull,
  input  wire logic [QUEUE_COUNT-1:0] queueAlmostFull,
  input  wire logic [QUEUE_COUNT-1:0] queueAlmostEmpty
);

  generate
    if (QUEUE_COUNT != QUADS * QUAD_BITS) begin : g_bad_count
      $error("queue count must fill four quadrants of eight");
    end
    // the address must split cleanly into device id and queue number
    if (ADDR_W != ID_W + QSEL_W || ID_LSB != QSEL_W) begin : g_bad_addr
      $error("device id and queue fields do not tile the address");
    end
    // quadrant field sits just above the queue-in-quadrant bits
    if (QUAD_LSB + QUAD_W != QSEL_W || (1 << QUAD_LSB) != QUAD_BITS) begin : g_bad_quad
      $error("quadrant field does not match the quadrant size");
    end
    if (QUADS != (1 << QUAD_W)) begin : g_bad_quads
      $error("quadrant counter cannot reach every quadrant");
    end
  endgenerate

  typedef struct packed {
    bus_mode_t          mode;
    logic [ID_W-1:0]    id;
    logic               startFull;
    logic               startEmpty;
    logic               fullOwned;
    logic [QSEL_W-1:0]  fullQueue;
    logic               fullValN;
    chan_t              afChan;
    chan_t              aeChan;
  } state_t;

  state_t st;
  state_t next_st;

  // per-quadrant images of the flag inputs, already in bus polarity
  logic [QUADS-1:0][QUAD_BITS-1:0] afViewN;
  logic [QUADS-1:0][QUAD_BITS-1:0] aeViewN;

  // quadrant q carries queues 8q to 8q+7, one bus line each
  genvar q;
  generate
    for (q = 0; q < QUADS; q = q + 1) begin : g_quad
      assign afViewN[q] = ~queueAlmostFull[q*QUAD_BITS +: QUAD_BITS];
      assign aeViewN[q] = ~queueAlmostEmpty[q*QUAD_BITS +: QUAD_BITS];
    end
  endgenerate

  // device part of a queue address, held against the id caught at reset
  function automatic logic ownsAddr(
    input logic [ADDR_W-1:0] addr,
    input logic [ID_W-1:0]   id
  );
    return addr[ID_LSB +: ID_W] == id;
  endfunction

  function automatic logic [QUAD_W-1:0] quadOf(input logic [ADDR_W-1:0] addr);
    return addr[QUAD_LSB +: QUAD_W];
  endfunction

  // a channel showing nothing: bus released high, no sync, no token
  function automatic chan_t idleChan();
    chan_t c;
    c.state    = CH_IDLE;
    c.quad     = QUAD_FIRST;
    c.sync     = 1'b0;
    c.tokenOut = 1'b0;
    c.busN     = BUS_IDLE_N;
    return c;
  endfunction

  // one status bus channel; shared by the almost-full and almost-empty sides
  function automatic chan_t stepChan(
    input chan_t                   c,
    input bus_mode_t               mode,
    input logic                    strobe,
    input logic [ADDR_W-1:0]       addr,
    input logic                    tokenIn,
    input logic                    start,
    input logic [ID_W-1:0]         id,
    input logic [QUADS-1:0][QUAD_BITS-1:0] viewN
  );
    chan_t n;
    n          = c;
    n.sync     = 1'b0;
    n.tokenOut = 1'b0;
    if (mode == MODE_DIRECT) begin
      if (strobe) begin
        n.state = ownsAddr(addr, id) ? CH_SHOW : CH_IDLE;
        n.quad  = quadOf(addr);
      end
    end else begin
      // a token arriving mid-sequence restarts at quadrant one
      // token loads quadrant one
      if (tokenIn || start) begin
        n.state = CH_SHOW;
        n.quad  = QUAD_FIRST;
      end else if (c.state == CH_SHOW) begin
        if (c.quad == QUAD_LAST) begin
          n.state = CH_IDLE;
        end else begin
          n.quad = c.quad + 2'h1;
        end
      end
      n.sync     = (n.state == CH_SHOW) && (n.quad == QUAD_FIRST);
      n.tokenOut = (n.state == CH_SHOW) && (n.quad == QUAD_LAST);
    end
    // eight consecutive queues, active low on the bus
    if (n.state == CH_SHOW) begin
      n.busN = viewN[n.quad];
    end else begin
      n.busN = BUS_IDLE_N;
    end
    return n;
  endfunction

  always_comb begin
    next_st = st;
    if (!reset_n) begin
      // mode and strap caught while reset is held
      next_st.mode       = bus_mode_t'(link.flagBusModeSelect);
      next_st.id         = deviceId;
      next_st.startFull  = ringLeader;
      next_st.startEmpty = ringLeader;
      next_st.fullOwned  = 1'b0;
      next_st.fullQueue  = '0;
      next_st.fullValN   = 1'b1;
      next_st.afChan     = idleChan();
      next_st.aeChan     = idleChan();
    end else begin
      // only the first edge after reset may start the ring from the leader
      next_st.startFull  = 1'b0;
      next_st.startEmpty = 1'b0;
      if (link.writeAddressStrobe) begin
        next_st.fullOwned = ownsAddr(link.writeQueueAddress, st.id);
        next_st.fullQueue = link.writeQueueAddress[QUEUE_LSB +: QSEL_W];
      end
      // refreshed each edge so a queue filling after selection still shows
      // full status of the selected queue, active low
      next_st.fullValN = ~queueFull[next_st.fullQueue];
      next_st.afChan = stepChan(st.afChan, st.mode, link.almostFullBusStrobe,
                                link.writeQueueAddress, link.fullTokenIn, st.startFull,
                                st.id, afViewN);
      next_st.aeChan = stepChan(st.aeChan, st.mode, link.almostEmptyBusStrobe,
                                link.readQueueAddress, link.emptyTokenIn, st.startEmpty,
                                st.id, aeViewN);
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // enable low only while this device owns the line
  assign link.writeQueueFullFlagEnN = ~st.fullOwned;
  assign link.writeQueueFullFlagOut = st.fullValN;
  assign link.almostFullStatusBusN  = st.afChan.busN;
  assign link.almostFullBusSync     = st.afChan.sync;
  assign link.fullTokenOut          = st.afChan.tokenOut;
  assign link.almostEmptyStatusBusN = st.aeChan.busN;
  assign link.almostEmptyBusSync    = st.aeChan.sync;
  assign link.emptyTokenOut         = st.aeChan.tokenOut;

endmodule // mq_flag_device
`default_nettype wire

// [mq_flag_user.sv]
// user logic beside a single device: APB registers drive selections and strobes
`timescale 1ns/1ps
`default_nettype none
module mq_flag_user
  import mq_flag_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  mq_flag_if.user          link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef struct packed {
    logic                   mode;
    logic [ADDR_W-1:0]      wAddr;
    logic [ADDR_W-1:0]      rAddr;
    logic                   wStrobe;
    logic                   fStrobe;
    logic                   eStrobe;
    logic                   refused;
    logic [WCOUNT_W-1:0]    writes;
    logic [31:0]            rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic   access;
  logic   mapped;
  logic   polled;

  function automatic logic isMapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_WSEL || a == REG_FSEL ||
           a == REG_ESEL || a == REG_WRITE || a == REG_STATUS;
  endfunction

  assign access = psel && penable;
  assign mapped = isMapped(paddr);
  assign polled = st.mode == MODE_POLLED;

  always_comb begin
    next_st         = st;
    next_st.wStrobe = 1'b0;
    next_st.fStrobe = 1'b0;
    next_st.eStrobe = 1'b0;
    // read data sampled in the setup cycle so it leaves a flip-flop
    if (psel && !penable) begin
      next_st.rdata = '0;
      unique case (paddr)
        REG_CTRL:   next_st.rdata[0] = st.mode;
        REG_WSEL:   next_st.rdata[ADDR_W-1:0] = st.wAddr;
        REG_ESEL:   next_st.rdata[ADDR_W-1:0] = st.rAddr;
        REG_STATUS: begin
          next_st.rdata[ST_FULL_N]  = link.writeQueueFullFlagN;
          next_st.rdata[ST_REFUSED] = st.refused;
          next_st.rdata[ST_AFSYNC]  = link.almostFullBusSync;
          next_st.rdata[ST_AESYNC]  = link.almostEmptyBusSync;
          next_st.rdata[ST_AFBUS +: QUAD_BITS] = link.almostFullStatusBusN;
          next_st.rdata[ST_AEBUS +: QUAD_BITS] = link.almostEmptyStatusBusN;
          next_st.rdata[ST_WCOUNT +: WCOUNT_W] = st.writes;
        end
        default: next_st.rdata = '0;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        // mode reaches the device only at its next reset; strobe gating and token loopback here follow it at once
        REG_CTRL: next_st.mode = pwdata[0];
        REG_WSEL: begin
          next_st.wAddr   = pwdata[ADDR_W-1:0];
          next_st.wStrobe = 1'b1;
        end
        // almost-full strobe kept low when polled
        REG_FSEL: begin
          next_st.wAddr   = pwdata[ADDR_W-1:0];
          next_st.fStrobe = !polled;
        end
        REG_ESEL: begin
          next_st.rAddr   = pwdata[ADDR_W-1:0];
          next_st.eStrobe = !polled;
        end
        // write only while full flag reads high
        REG_WRITE: begin
          if (link.writeQueueFullFlagN && !st.wStrobe) begin
            next_st.writes = st.writes + 8'h01;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        // status is read-only; a write clears the sticky refusal bit
        REG_STATUS: next_st.refused = 1'b0;
        default: next_st.refused = st.refused;
      endcase
    end
    if (!reset_n) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = st.rdata;

  assign link.flagBusModeSelect    = st.mode;
  assign link.writeQueueAddress    = st.wAddr;
  assign link.writeAddressStrobe   = st.wStrobe;
  assign link.almostFullBusStrobe  = st.fStrobe;
  assign link.readQueueAddress     = st.rAddr;
  assign link.almostEmptyBusStrobe = st.eStrobe;
  // single device: loop back when polled, low when direct
  assign link.fullTokenIn          = polled && link.fullTokenOut;
  assign link.emptyTokenIn         = polled && link.emptyTokenOut;

endmodule // mq_flag_user
`default_nettype wire

// [mq_flag_chk.sv]
// concurrent checks on the flag link between one device and its user logic
`timescale 1ns/1ps
`default_nettype none
module mq_flag_chk
  import mq_flag_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic [ID_W-1:0]      deviceId,
  input wire logic                 flagBusModeSelect,
  input wire logic [ADDR_W-1:0]    writeQueueAddress,
  input wire logic                 writeAddressStrobe,
  input wire logic                 almostFullBusStrobe,
  input wire logic                 almostEmptyBusStrobe,
  input wire logic                 fullTokenIn,
  input wire logic                 emptyTokenIn,
  input wire logic                 fullTokenOut,
  input wire logic                 emptyTokenOut,
  input wire logic                 writeQueueFullFlagEnN,
  input wire logic [QUAD_BITS-1:0] almostFullStatusBusN,
  input wire logic                 almostFullBusSync,
  input wire logic                 almostEmptyBusSync
);
  logic            polled;
  logic [ID_W-1:0] wDev;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  assign wDev = writeQueueAddress[ID_LSB+:ID_W];
  // mode as the device caught it while held in reset
  always_ff @(posedge clk)
    if (!reset_n)
      polled <= flagBusModeSelect;

  AST_SEL_OWNER:
    assert property (writeAddressStrobe |=> writeQueueFullFlagEnN == ($past(wDev) != deviceId))
    else $error("full line owner wrong after select");
  AST_SEL_HOLD:
    assert property (!writeAddressStrobe |=> $stable(writeQueueFullFlagEnN))
    else $error("full line drive changed without select");
  AST_AF_IDLE:
    assert property (!polled && almostFullBusStrobe && wDev != deviceId
                     |=> almostFullStatusBusN == BUS_IDLE_N)
    else $error("foreign quadrant not idle on almost-full bus");
  AST_DIRECT_NOSYNC:
    assert property (!polled |-> !almostFullBusSync && !almostEmptyBusSync)
    else $error("sync seen in direct mode");
  AST_AF_ROTATE:
    assert property (almostFullBusSync |=> !almostFullBusSync [*3] ##1 almostFullBusSync)
    else $error("almost-full rotation not four cycles");
  AST_AE_ROTATE:
    assert property ($fell(almostEmptyBusSync) |-> ##2 !almostEmptyBusSync ##1 almostEmptyBusSync)
    else $error("almost-empty rotation not four cycles");
  AST_AF_TOKEN:
    assert property (almostFullBusSync |-> ##3 fullTokenOut)
    else $error("full token missing after fourth quadrant");
  AST_AE_TOKEN:
    assert property ($rose(emptyTokenOut) |-> $past(almostEmptyBusSync, 3))
    else $error("empty token not three cycles after first quadrant");
  AST_TOKEN_PULSE:
    assert property (fullTokenOut || emptyTokenOut |=> !fullTokenOut && !emptyTokenOut)
    else $error("token longer than one cycle");
  AST_LOOP_BACK:
    assert property (flagBusModeSelect |-> fullTokenIn == fullTokenOut
                     && emptyTokenIn == emptyTokenOut)
    else $error("token not looped back in polled mode");
  AST_DIRECT_TIE:
    assert property (!flagBusModeSelect |-> !fullTokenIn && !emptyTokenIn)
    else $error("token input not low in direct mode");
  AST_POLL_STROBE:
    assert property (flagBusModeSelect |-> !almostFullBusStrobe && !almostEmptyBusStrobe)
    else $error("bus strobe raised in polled mode");

  cover property (almostFullBusSync ##4 almostFullBusSync);
  cover property (writeAddressStrobe ##1 !writeQueueFullFlagEnN);
  cover property (emptyTokenOut);
endmodule // mq_flag_chk
`default_nettype wire

// [testbench.sv]
// self-checking bench: user logic and one device joined by the flag link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mq_flag_pkg::*;
  localparam logic [ID_W-1:0] DEV = 3'h2;
  logic        clk, devRst_n, usrRst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        refused, line;
  logic [7:0]  paddr, wA, fA, eA, cnt;
  logic [31:0] pwdata, prdata, qF, qAF, qAE, rd;
  integer      seed, badCount, totalChecks, i, k;

  mq_flag_if link ();
  mq_flag_device mq_flag_device_i (.clk(clk), .reset_n(devRst_n), .link(link),
    .deviceId(DEV), .ringLeader(1'b1), .queueFull(qF), .queueAlmostFull(qAF),
    .queueAlmostEmpty(qAE));
  mq_flag_user mq_flag_user_i (.clk(clk), .reset_n(usrRst_n), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mq_flag_chk mq_flag_chk_i (.clk(clk), .reset_n(devRst_n), .deviceId(DEV),
    .flagBusModeSelect(link.flagBusModeSelect), .writeQueueAddress(link.writeQueueAddress),
    .writeAddressStrobe(link.writeAddressStrobe), .almostFullBusStrobe(link.almostFullBusStrobe),
    .almostEmptyBusStrobe(link.almostEmptyBusStrobe), .fullTokenIn(link.fullTokenIn),
    .emptyTokenIn(link.emptyTokenIn), .fullTokenOut(link.fullTokenOut),
    .emptyTokenOut(link.emptyTokenOut), .writeQueueFullFlagEnN(link.writeQueueFullFlagEnN),
    .almostFullStatusBusN(link.almostFullStatusBusN), .almostFullBusSync(link.almostFullBusSync),
    .almostEmptyBusSync(link.almostEmptyBusSync));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // quadrant image on an active-low status bus; foreign device shows idle
  function automatic logic [7:0] quad(input logic [31:0] f, input logic [7:0] a);
    return (a[7:5] == DEV) ? ~f[a[4:3]*8+:8] : BUS_IDLE_N;
  endfunction

  task automatic finishTest;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    badCount++;
    finishTest();
  end

  initial begin
    seed = 27951;
    {badCount, totalChecks, cnt, refused} = '0;
    {devRst_n, usrRst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {qF, qAF, qAE} = '0;
    // id 7 is foreign, so buses start idle and the line undriven
    {fA, eA} = {8'hE0, 8'hE0};
    repeat (8) @(posedge clk);
    devRst_n <= 1'b1;
    usrRst_n <= 1'b1;
    apb(1'b1, 8'h18, 32'hA5);
    check(err, 1'b1);
    apb(1'b0, 8'h1C, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    for (i = 0; i < 12; i++) begin
      qF <= $random(seed);
      qAF <= $random(seed);
      qAE <= $random(seed);
      wA = {($random(seed) & 1) ? DEV : 3'h5, 5'($random(seed))};
      fA = {($random(seed) & 1) ? DEV : 3'h6, i[1:0], 3'($random(seed))};
      eA = {($random(seed) & 1) ? DEV : 3'h1, i[1:0], 3'($random(seed))};
      apb(1'b1, REG_WSEL, {24'h0, wA});
      apb(1'b1, REG_FSEL, {24'h0, fA});
      apb(1'b1, REG_ESEL, {24'h0, eA});
      if (i == 6) begin
        apb(1'b1, REG_STATUS, 32'h0);
        refused = 1'b0;
      end
      line = (wA[7:5] == DEV) ? ~qF[wA[4:0]] : 1'b1;
      apb(1'b1, REG_WRITE, 32'h0);
      if (line)
        cnt++;
      else
        refused = 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, {cnt, quad(qAE, eA), quad(qAF, fA), 6'h0, refused, line});
    end
    // mode is only taken while the device sits in reset
    apb(1'b1, REG_CTRL, 32'h1);
    devRst_n <= 1'b0;
    repeat (2) @(posedge clk);
    devRst_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 10; k++) begin
      // sample mid-cycle, where the registered outputs have settled
      @(negedge clk);
      check(link.almostFullStatusBusN, quad(qAF, {DEV, 2'(k), 3'h0}));
      check(link.almostEmptyStatusBusN, quad(qAE, {DEV, 2'(k), 3'h0}));
      check({link.almostFullBusSync, link.almostEmptyBusSync}, (k % 4 == 0) ? 2'h3 : 2'h0);
      check({link.fullTokenOut, link.emptyTokenOut}, (k % 4 == 3) ? 2'h3 : 2'h0);
    end
    apb(1'b1, REG_FSEL, 32'h48);
    repeat (4) @(posedge clk);
    finishTest();
  end
endmodule // testbench
`default_nettype wire
